//--- hdl/csmsw_sfr_bank.sv
/*
 core register bank: direct register space, on-chip scratch RAM, status flags,
 stack pointer, working register banks and routing of program and external data access.
 assumes: the core issues one request per cycle when ready; external and on-chip
 program memories answer on mem_rdata in the same cycle that mem.valid is high.
*/
`timescale 1ns/100ps

module csmsw_sfr_bank #(
   parameter logic EXTENDED = 1'b1
) (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   // core access port
   input  wire csmsw_pkg::csmsw_req_t  req,
   output logic                        req_ready,
   output csmsw_pkg::csmsw_rsp_t       rsp,
   // execution unit results
   input  wire csmsw_pkg::csmsw_alu_t    alu_upd,
   input  wire csmsw_pkg::csmsw_muldiv_t muldiv,
   input  wire logic                     instr_end,
   // program and external data memory
   output csmsw_pkg::csmsw_mem_t       mem,
   input  wire logic [7:0]             mem_rdata,
   input  wire logic                   ext_fetch_only,
   // register view for the core
   output csmsw_pkg::csmsw_view_t      view
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic reg_present(input logic [7:0] a, input logic ext);
      case (a)
         csmsw_pkg::REG_PORT0_LATCH, csmsw_pkg::REG_STACK_POINTER,
         csmsw_pkg::REG_DATA_PTR_LOW, csmsw_pkg::REG_DATA_PTR_HIGH,
         csmsw_pkg::REG_POWER_CONTROL, csmsw_pkg::REG_TIMER_RUN,
         csmsw_pkg::REG_TIMER_MODE, csmsw_pkg::REG_TIMER0_LOW,
         csmsw_pkg::REG_TIMER1_LOW, csmsw_pkg::REG_TIMER0_HIGH,
         csmsw_pkg::REG_TIMER1_HIGH, csmsw_pkg::REG_PORT1_LATCH,
         csmsw_pkg::REG_SERIAL_CONTROL, csmsw_pkg::REG_SERIAL_BUFFER,
         csmsw_pkg::REG_PORT2_LATCH, csmsw_pkg::REG_INT_ENABLE,
         csmsw_pkg::REG_PORT3_LATCH, csmsw_pkg::REG_INT_PRIORITY,
         csmsw_pkg::REG_STATUS_FLAGS, csmsw_pkg::REG_ARITH_RESULT,
         csmsw_pkg::REG_MULTIPLY_AUX: begin
            reg_present = 1'b1;
         end
         csmsw_pkg::REG_TIMER2_CONTROL, csmsw_pkg::REG_TIMER2_RLD_LOW,
         csmsw_pkg::REG_TIMER2_RLD_HI, csmsw_pkg::REG_TIMER2_LOW,
         csmsw_pkg::REG_TIMER2_HIGH: begin
            reg_present = ext;
         end
         default: begin
            reg_present = 1'b0;
         end
      endcase
   endfunction

   // upper half of the RAM exists only on the extended variant
   function automatic logic ram_present(input logic [7:0] a, input logic ext);
      ram_present = (a < csmsw_pkg::DIRECT_REG_BASE) || ext;
   endfunction

   // direct addresses above 7FH go to registers, below to RAM
   function automatic logic [7:0] read_direct(input csmsw_pkg::csmsw_state_t st,
                                              input logic [7:0]               a,
                                              input logic                     ext);
      if (a >= csmsw_pkg::DIRECT_REG_BASE) begin
         read_direct = reg_present(a, ext) ? st.spec[a[6:0]] : csmsw_pkg::UNMAPPED_READ;
      end else begin
         read_direct = st.ram[a];
      end
   endfunction

   function automatic csmsw_pkg::csmsw_state_t put_direct(
         input csmsw_pkg::csmsw_state_t st,
         input logic [7:0]               a,
         input logic [7:0]               d,
         input logic                     ext);
      put_direct = st;
      if (a >= csmsw_pkg::DIRECT_REG_BASE) begin
         if (a == csmsw_pkg::REG_STATUS_FLAGS) begin
            // parity is owned by hardware; reserved bit stores as written
            put_direct.spec[a[6:0]] = {d[7:1],
                                       st.spec[a[6:0]][csmsw_pkg::FLAG_PARITY]};
         end else if (reg_present(a, ext)) begin
            put_direct.spec[a[6:0]] = d;
         end
      end else begin
         put_direct.ram[a] = d;
      end
   endfunction

   // bit address to its home byte
   function automatic logic [7:0] bit_home(input logic [7:0] b);
      if (b[7]) begin
         bit_home = {b[7:3], 3'b000};
      end else begin
         bit_home = csmsw_pkg::BIT_RAM_BASE + {4'h0, b[6:3]};
      end
   endfunction

   // only addresses ending 000B carry bit access in register space
   function automatic logic bit_reachable(input logic [7:0] home, input logic ext);
      bit_reachable = !home[7] || reg_present(home, ext);
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   csmsw_pkg::csmsw_state_t s_reg;
   csmsw_pkg::csmsw_state_t s_next;

   localparam logic [6:0] IDX_STACK  = csmsw_pkg::REG_STACK_POINTER[6:0];
   localparam logic [6:0] IDX_FLAGS  = csmsw_pkg::REG_STATUS_FLAGS[6:0];
   localparam logic [6:0] IDX_RESULT = csmsw_pkg::REG_ARITH_RESULT[6:0];
   localparam logic [6:0] IDX_AUX    = csmsw_pkg::REG_MULTIPLY_AUX[6:0];

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [7:0] a;
      logic [7:0] byte_val;
      logic [7:0] sp_val;
      logic [15:0] onchip_limit;
      a            = 8'h00;
      byte_val     = 8'h00;
      sp_val       = s_reg.spec[IDX_STACK];
      onchip_limit = EXTENDED ? csmsw_pkg::PROG_ONCHIP_EXT : csmsw_pkg::PROG_ONCHIP_BASE;
      s_next           = s_reg;
      s_next.rsp.valid = 1'b0;
      s_next.mem.valid = 1'b0;

      case (s_reg.fsm)
         csmsw_pkg::ST_WAIT: begin
            s_next.rsp.valid   = 1'b1;
            s_next.rsp.rdata   = mem_rdata;
            s_next.rsp.bit_val = 1'b0;
            s_next.fsm         = csmsw_pkg::ST_IDLE;
         end
         csmsw_pkg::ST_IDLE: begin
            if (req.valid) begin
               s_next.rsp.valid   = 1'b1;
               s_next.rsp.rdata   = req.wdata;
               s_next.rsp.bit_val = 1'b0;
               case (req.op)
                  csmsw_pkg::OP_DIRECT_RD: begin
                     s_next.rsp.rdata = read_direct(s_reg, req.addr[7:0], EXTENDED);
                  end
                  csmsw_pkg::OP_DIRECT_WR: begin
                     s_next = put_direct(s_next, req.addr[7:0], req.wdata, EXTENDED);
                  end
                  csmsw_pkg::OP_INDIRECT_RD: begin
                     a = req.addr[7:0];
                     s_next.rsp.rdata = ram_present(a, EXTENDED) ? s_reg.ram[a]
                                                                 : csmsw_pkg::UNMAPPED_READ;
                  end
                  csmsw_pkg::OP_INDIRECT_WR: begin
                     a = req.addr[7:0];
                     if (ram_present(a, EXTENDED)) begin
                        s_next.ram[a] = req.wdata;
                     end
                  end
                  csmsw_pkg::OP_WORKREG_RD: begin
                     a = {3'b000, s_reg.bank_active, req.addr[2:0]};
                     s_next.rsp.rdata = s_reg.ram[a];
                  end
                  csmsw_pkg::OP_WORKREG_WR: begin
                     a = {3'b000, s_reg.bank_active, req.addr[2:0]};
                     s_next.ram[a] = req.wdata;
                  end
                  csmsw_pkg::OP_BIT_RD: begin
                     a        = bit_home(req.addr[7:0]);
                     byte_val = bit_reachable(a, EXTENDED) ? read_direct(s_reg, a, EXTENDED)
                                                           : csmsw_pkg::UNMAPPED_READ;
                     s_next.rsp.rdata   = byte_val;
                     s_next.rsp.bit_val = byte_val[req.addr[2:0]];
                  end
                  csmsw_pkg::OP_BIT_WR: begin
                     a = bit_home(req.addr[7:0]);
                     if (bit_reachable(a, EXTENDED)) begin
                        byte_val = read_direct(s_reg, a, EXTENDED);
                        byte_val[req.addr[2:0]] = req.wdata[0];
                        s_next = put_direct(s_next, a, byte_val, EXTENDED);
                     end
                     s_next.rsp.rdata   = byte_val;
                     s_next.rsp.bit_val = req.wdata[0];
                  end
                  csmsw_pkg::OP_PUSH: begin
                     // increment first, then store at the new top
                     sp_val = s_reg.spec[IDX_STACK] + 8'h01;
                     s_next.spec[IDX_STACK] = sp_val;
                     if (ram_present(sp_val, EXTENDED)) begin
                        s_next.ram[sp_val] = req.wdata;
                     end
                  end
                  csmsw_pkg::OP_POP: begin
                     s_next.rsp.rdata = ram_present(sp_val, EXTENDED) ? s_reg.ram[sp_val]
                                                                      : csmsw_pkg::UNMAPPED_READ;
                     s_next.spec[IDX_STACK] = sp_val - 8'h01;
                  end
                  csmsw_pkg::OP_PROG_RD: begin
                     // program space never reaches the data stores
                     s_next.rsp.valid = 1'b0;
                     s_next.mem.valid = 1'b1;
                     s_next.mem.write = 1'b0;
                     s_next.mem.addr  = req.addr;
                     s_next.mem.wdata = 8'h00;
                     s_next.mem.space = (!ext_fetch_only && req.addr < onchip_limit)
                                        ? csmsw_pkg::MEM_PROG_ONCHIP
                                        : csmsw_pkg::MEM_PROG_EXT;
                     s_next.fsm = csmsw_pkg::ST_WAIT;
                  end
                  csmsw_pkg::OP_XDATA_RD: begin
                     s_next.rsp.valid = 1'b0;
                     s_next.mem.valid = 1'b1;
                     s_next.mem.space = csmsw_pkg::MEM_XDATA;
                     s_next.mem.write = 1'b0;
                     s_next.mem.addr  = req.addr;
                     s_next.mem.wdata = 8'h00;
                     s_next.fsm = csmsw_pkg::ST_WAIT;
                  end
                  csmsw_pkg::OP_XDATA_WR: begin
                     s_next.mem.valid = 1'b1;
                     s_next.mem.space = csmsw_pkg::MEM_XDATA;
                     s_next.mem.write = 1'b1;
                     s_next.mem.addr  = req.addr;
                     s_next.mem.wdata = req.wdata;
                  end
                  default: begin
                     s_next.rsp.rdata = csmsw_pkg::UNMAPPED_READ;
                  end
               endcase
            end
         end
         default: begin
            s_next.fsm = csmsw_pkg::ST_IDLE;
         end
      endcase

      // execution results win over a same-cycle register write
      if (muldiv.valid) begin
         s_next.spec[IDX_RESULT] = muldiv.result;
         s_next.spec[IDX_AUX]    = muldiv.aux;
      end
      if (alu_upd.valid) begin
         if (alu_upd.result_we) begin
            s_next.spec[IDX_RESULT] = alu_upd.result;
         end
         if (alu_upd.carry_we) begin
            s_next.spec[IDX_FLAGS][csmsw_pkg::FLAG_CARRY] = alu_upd.carry;
         end
         if (alu_upd.nibble_we) begin
            s_next.spec[IDX_FLAGS][csmsw_pkg::FLAG_NIBBLE] = alu_upd.nibble;
         end
         if (alu_upd.overflow_we) begin
            s_next.spec[IDX_FLAGS][csmsw_pkg::FLAG_OVERFLOW] = alu_upd.overflow;
         end
      end

      // instruction boundary: parity refresh and bank switch
      if (instr_end) begin
         s_next.spec[IDX_FLAGS][csmsw_pkg::FLAG_PARITY] = ^s_next.spec[IDX_RESULT];
         s_next.bank_active = {s_next.spec[IDX_FLAGS][csmsw_pkg::FLAG_BANK_HIGH],
                               s_next.spec[IDX_FLAGS][csmsw_pkg::FLAG_BANK_LOW]};
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_reg                  <= '0;
         s_reg.fsm              <= csmsw_pkg::ST_IDLE;
         s_reg.spec[IDX_STACK]  <= csmsw_pkg::STACK_PTR_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // ready drops only while a memory read is outstanding
   assign req_ready = (s_reg.fsm == csmsw_pkg::ST_IDLE);
   assign rsp       = s_reg.rsp;
   assign mem       = s_reg.mem;

   assign view.arith_result      = s_reg.spec[IDX_RESULT];
   assign view.status_flags      = s_reg.spec[IDX_FLAGS];
   assign view.stack_pointer     = s_reg.spec[IDX_STACK];
   assign view.data_pointer_pair = {s_reg.spec[csmsw_pkg::REG_DATA_PTR_HIGH[6:0]],
                                    s_reg.spec[csmsw_pkg::REG_DATA_PTR_LOW[6:0]]};
   assign view.bank_active       = s_reg.bank_active;
   assign view.port_latch        = {s_reg.spec[csmsw_pkg::REG_PORT3_LATCH[6:0]],
                                    s_reg.spec[csmsw_pkg::REG_PORT2_LATCH[6:0]],
                                    s_reg.spec[csmsw_pkg::REG_PORT1_LATCH[6:0]],
                                    s_reg.spec[csmsw_pkg::REG_PORT0_LATCH[6:0]]};

endmodule

//--- hdl/csmsw_pkg.sv
/*
 package of the core register bank: direct-space addresses, flag bit positions,
 memory sizes, reset values and the structs that carry requests, answers and state.
 assumes: one clock, one core access per cycle, memories served outside the block.
*/

package csmsw_pkg;

   // ---------------------------------------------------------------
   // direct-space register addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_PORT0_LATCH    = 8'h80;
   localparam logic [7:0] REG_STACK_POINTER  = 8'h81;
   localparam logic [7:0] REG_DATA_PTR_LOW   = 8'h82;
   localparam logic [7:0] REG_DATA_PTR_HIGH  = 8'h83;
   localparam logic [7:0] REG_POWER_CONTROL  = 8'h87;
   localparam logic [7:0] REG_TIMER_RUN      = 8'h88;
   localparam logic [7:0] REG_TIMER_MODE     = 8'h89;
   localparam logic [7:0] REG_TIMER0_LOW     = 8'h8a;
   localparam logic [7:0] REG_TIMER1_LOW     = 8'h8b;
   localparam logic [7:0] REG_TIMER0_HIGH    = 8'h8c;
   localparam logic [7:0] REG_TIMER1_HIGH    = 8'h8d;
   localparam logic [7:0] REG_PORT1_LATCH    = 8'h90;
   localparam logic [7:0] REG_SERIAL_CONTROL = 8'h98;
   localparam logic [7:0] REG_SERIAL_BUFFER  = 8'h99;
   localparam logic [7:0] REG_PORT2_LATCH    = 8'ha0;
   localparam logic [7:0] REG_INT_ENABLE     = 8'ha8;
   localparam logic [7:0] REG_PORT3_LATCH    = 8'hb0;
   localparam logic [7:0] REG_INT_PRIORITY   = 8'hb8;
   localparam logic [7:0] REG_TIMER2_CONTROL = 8'hc8;
   localparam logic [7:0] REG_TIMER2_RLD_LOW = 8'hca;
   localparam logic [7:0] REG_TIMER2_RLD_HI  = 8'hcb;
   localparam logic [7:0] REG_TIMER2_LOW     = 8'hcc;
   localparam logic [7:0] REG_TIMER2_HIGH    = 8'hcd;
   localparam logic [7:0] REG_STATUS_FLAGS   = 8'hd0;
   localparam logic [7:0] REG_ARITH_RESULT   = 8'he0;
   localparam logic [7:0] REG_MULTIPLY_AUX   = 8'hf0;

   // ---------------------------------------------------------------
   // status flag positions
   // ---------------------------------------------------------------
   localparam int FLAG_CARRY     = 7;
   localparam int FLAG_NIBBLE    = 6;
   localparam int FLAG_USER      = 5;
   localparam int FLAG_BANK_HIGH = 4;
   localparam int FLAG_BANK_LOW  = 3;
   localparam int FLAG_OVERFLOW  = 2;
   localparam int FLAG_RESERVED  = 1;
   localparam int FLAG_PARITY    = 0;

   // ---------------------------------------------------------------
   // sizes, limits and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0]  DIRECT_REG_BASE   = 8'h80;
   localparam logic [7:0]  BIT_RAM_BASE      = 8'h20;
   localparam int          RAM_BYTES_BASE    = 128;
   localparam int          RAM_BYTES_EXT     = 256;
   localparam logic [15:0] PROG_ONCHIP_BASE  = 16'h1000;
   localparam logic [15:0] PROG_ONCHIP_EXT   = 16'h2000;
   localparam logic [7:0]  STACK_PTR_RESET   = 8'h07;
   localparam logic [7:0]  REG_RESET         = 8'h00;
   localparam logic [7:0]  UNMAPPED_READ     = 8'h00;

   // ---------------------------------------------------------------
   // commands, states and carriers
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_DIRECT_RD   = 4'h0,
      OP_DIRECT_WR   = 4'h1,
      OP_INDIRECT_RD = 4'h2,
      OP_INDIRECT_WR = 4'h3,
      OP_WORKREG_RD  = 4'h4,
      OP_WORKREG_WR  = 4'h5,
      OP_BIT_RD      = 4'h6,
      OP_BIT_WR      = 4'h7,
      OP_PUSH        = 4'h8,
      OP_POP         = 4'h9,
      OP_PROG_RD     = 4'ha,
      OP_XDATA_RD    = 4'hb,
      OP_XDATA_WR    = 4'hc
   } csmsw_op_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h1,
      ST_WAIT = 2'h2
   } csmsw_fsm_t;

   typedef enum logic [1:0] {
      MEM_PROG_ONCHIP = 2'h0,
      MEM_PROG_EXT    = 2'h1,
      MEM_XDATA       = 2'h2
   } csmsw_space_t;

   typedef struct packed {
      logic        valid;
      csmsw_op_t   op;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } csmsw_req_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] rdata;
      logic       bit_val;
   } csmsw_rsp_t;

   typedef struct packed {
      logic       valid;
      logic       carry_we;
      logic       carry;
      logic       nibble_we;
      logic       nibble;
      logic       overflow_we;
      logic       overflow;
      logic       result_we;
      logic [7:0] result;
   } csmsw_alu_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] result;
      logic [7:0] aux;
   } csmsw_muldiv_t;

   typedef struct packed {
      logic         valid;
      csmsw_space_t space;
      logic         write;
      logic [15:0]  addr;
      logic [7:0]   wdata;
   } csmsw_mem_t;

   typedef struct packed {
      logic [7:0]  arith_result;
      logic [7:0]  status_flags;
      logic [7:0]  stack_pointer;
      logic [15:0] data_pointer_pair;
      logic [1:0]  bank_active;
      logic [3:0][7:0] port_latch;
   } csmsw_view_t;

   typedef struct packed {
      csmsw_fsm_t       fsm;
      logic [127:0][7:0] spec;
      logic [255:0][7:0] ram;
      logic [1:0]       bank_active;
      csmsw_rsp_t       rsp;
      csmsw_mem_t       mem;
   } csmsw_state_t;

endpackage

//--- bench/csmsw_props.sv
/*
 checker of the register bank ports: stack, parity, banks, multiply and memory routing.
 assumes: bound to csmsw_sfr_bank, one clock, asynchronous active-low reset.
*/
`timescale 1ns/100ps
module csmsw_props #(
   parameter logic EXTENDED = 1'b1
) (
   // clock and reset
   input wire logic                     clk,
   input wire logic                     reset_n,
   // observed ports
   input wire csmsw_pkg::csmsw_req_t    req,
   input wire logic                     req_ready,
   input wire csmsw_pkg::csmsw_rsp_t    rsp,
   input wire csmsw_pkg::csmsw_muldiv_t muldiv,
   input wire csmsw_pkg::csmsw_alu_t    alu_upd,
   input wire logic                     instr_end,
   input wire csmsw_pkg::csmsw_mem_t    mem,
   input wire logic [7:0]               mem_rdata,
   input wire logic                     ext_fetch_only,
   input wire csmsw_pkg::csmsw_view_t   view
);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   localparam logic [15:0] LIM = EXTENDED ? csmsw_pkg::PROG_ONCHIP_EXT
                                          : csmsw_pkg::PROG_ONCHIP_BASE;
   logic take;
   assign take = req.valid && req_ready;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_push_step: assert property (take && req.op == csmsw_pkg::OP_PUSH |=>
      view.stack_pointer == $past(view.stack_pointer) + 8'h01)
      else $error("stack pointer did not step on push");
   a_parity_even: assert property (instr_end |=>
      !(^{view.arith_result, view.status_flags[0]})) else $error("parity not even");
   a_bank_load: assert property (instr_end && !req.valid |=>
      view.bank_active == view.status_flags[4:3]) else $error("bank not loaded");
   a_bank_hold: assert property (!instr_end |=> $stable(view.bank_active))
      else $error("bank moved between instructions");
   a_muldiv_load: assert property (muldiv.valid && !take &&
      !(alu_upd.valid && alu_upd.result_we) |=> view.arith_result == $past(muldiv.result))
      else $error("multiply result lost");
   a_xdata_space: assert property (take && (req.op == csmsw_pkg::OP_XDATA_RD ||
      req.op == csmsw_pkg::OP_XDATA_WR) |=> mem.valid && mem.space == csmsw_pkg::MEM_XDATA
      && mem.addr == $past(req.addr)) else $error("external data access misrouted");
   a_prog_space: assert property (take && req.op == csmsw_pkg::OP_PROG_RD |=>
      mem.valid && mem.space != csmsw_pkg::MEM_XDATA && (mem.space == csmsw_pkg::MEM_PROG_ONCHIP)
      == (!$past(ext_fetch_only) && $past(req.addr) < LIM)) else $error("fetch misrouted");
   a_read_wait: assert property (take && (req.op == csmsw_pkg::OP_PROG_RD ||
      req.op == csmsw_pkg::OP_XDATA_RD) |=> !req_ready ##1 rsp.valid && rsp.rdata ==
      $past(mem_rdata)) else $error("memory read answer wrong");
endmodule

bind csmsw_sfr_bank csmsw_props #(.EXTENDED(EXTENDED)) props_u (.clk(clk), .reset_n(reset_n),
   .req(req), .req_ready(req_ready), .rsp(rsp), .muldiv(muldiv), .alu_upd(alu_upd),
   .instr_end(instr_end),
   .mem(mem), .mem_rdata(mem_rdata), .ext_fetch_only(ext_fetch_only), .view(view));

//--- bench/csmsw_sfr_bank_test.sv
/*
 bench of the register bank: register table, banks, parity, stack, memory routing.
 assumes: extended variant as dut_u, base variant as base_u beside it; checker bound by its own file.
*/
`timescale 1ns/100ps
module csmsw_sfr_bank_test;
   logic                     clk = 1'b0;
   logic                     reset_n = 1'b0;
   csmsw_pkg::csmsw_req_t    req = '0;
   logic                     req_ready;
   csmsw_pkg::csmsw_rsp_t    rsp;
   csmsw_pkg::csmsw_alu_t    alu_upd = '0;
   csmsw_pkg::csmsw_muldiv_t muldiv = '0;
   logic                     instr_end = 1'b0;
   csmsw_pkg::csmsw_mem_t    mem;
   logic [7:0]               mem_rdata = 8'h00;
   logic                     ext_fetch_only = 1'b0;
   csmsw_pkg::csmsw_view_t   view;
   csmsw_pkg::csmsw_rsp_t    rsp_base;
   logic [7:0]               expq[$];
   logic [7:0]               rnd = 8'h4b;
   int                       fail_count = 0;
   int                       n_compared = 0;
   logic [7:0]               regs[24] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h88, 8'h89,
      8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h90, 8'h98, 8'ha0, 8'ha8, 8'hb0, 8'hb8, 8'hc8, 8'hca,
      8'hcb, 8'hcc, 8'hcd, 8'he0, 8'hf0};

   csmsw_sfr_bank #(.EXTENDED(1'b1)) dut_u (.clk(clk), .reset_n(reset_n), .req(req),
      .req_ready(req_ready), .rsp(rsp), .alu_upd(alu_upd), .muldiv(muldiv),
      .instr_end(instr_end), .mem(mem), .mem_rdata(mem_rdata),
      .ext_fetch_only(ext_fetch_only), .view(view));
   csmsw_sfr_bank #(.EXTENDED(1'b0)) base_u (.clk(clk), .reset_n(reset_n), .req(req),
      .req_ready(), .rsp(rsp_base), .alu_upd(alu_upd), .muldiv(muldiv),
      .instr_end(instr_end), .mem(), .mem_rdata(mem_rdata),
      .ext_fetch_only(ext_fetch_only), .view());

   always #5 clk = ~clk;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] next_rand(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   // request held until ready is seen high at the falling edge before the taking edge
   task automatic op(input csmsw_pkg::csmsw_op_t o, input logic [15:0] a,
                     input logic [7:0] d, input logic [7:0] e);
      logic ok;
      req <= '{1'b1, o, a, d};
      expq.push_back(e);
      do begin
         @(negedge clk);
         ok = req_ready;
         @(posedge clk);
      end while (!ok);
   endtask

   task automatic idle(input int n);
      req.valid <= 1'b0;
      repeat (n) @(posedge clk);
   endtask

   task automatic pulse();
      req.valid <= 1'b0;
      instr_end <= 1'b1;
      @(posedge clk);
      instr_end <= 1'b0;
      @(posedge clk);
   endtask

   task automatic summarize();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      if (rsp.valid === 1'b1) begin
         check("rdata", rsp.rdata, expq.pop_front());
      end
   end

   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      check("stack", view.stack_pointer, 8'h07);
      foreach (regs[i]) begin
         rnd = next_rand(rnd);
         op(csmsw_pkg::OP_DIRECT_WR, {8'h00, regs[i]}, rnd, rnd);
         op(csmsw_pkg::OP_DIRECT_RD, {8'h00, regs[i]}, 8'h00, rnd);
         idle(0);
         @(negedge clk);
         check("base", rsp_base.rdata, regs[i][7:4] == 4'hc ? 8'h00 : rnd);
         @(posedge clk);
      end
      op(csmsw_pkg::OP_DIRECT_RD, 16'h0084, 8'h00, 8'h00);
      for (int b = 0; b < 4; b++) begin
         op(csmsw_pkg::OP_DIRECT_WR, 16'h00d0, 8'(b << 3), 8'(b << 3));
         pulse();
         check("bank", {6'h00, view.bank_active}, 8'(b));
         rnd = next_rand(rnd);
         op(csmsw_pkg::OP_WORKREG_WR, 16'h0005, rnd, rnd);
         op(csmsw_pkg::OP_WORKREG_RD, 16'h0005, 8'h00, rnd);
         op(csmsw_pkg::OP_DIRECT_RD, 16'(b * 8 + 5), 8'h00, rnd);
      end
      op(csmsw_pkg::OP_DIRECT_WR, 16'h00e0, rnd, rnd);
      pulse();
      check("parity", {7'h00, view.status_flags[0]}, {7'h00, ^rnd});
      op(csmsw_pkg::OP_DIRECT_WR, 16'h00d0, 8'he6, 8'he6);
      op(csmsw_pkg::OP_DIRECT_RD, 16'h00d0, 8'h00, {7'h73, ^rnd});
      idle(0);
      alu_upd <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00};
      muldiv <= '{1'b1, 8'h5a, 8'ha5};
      @(posedge clk);
      alu_upd.valid <= 1'b0;
      muldiv.valid <= 1'b0;
      op(csmsw_pkg::OP_DIRECT_RD, 16'h00d0, 8'h00, {7'h11, ^rnd});
      op(csmsw_pkg::OP_DIRECT_RD, 16'h00f0, 8'h00, 8'ha5);
      op(csmsw_pkg::OP_DIRECT_WR, 16'h0081, 8'h2f, 8'h2f);
      op(csmsw_pkg::OP_PUSH, 16'h0000, 8'h55, 8'h55);
      op(csmsw_pkg::OP_DIRECT_RD, 16'h0030, 8'h00, 8'h55);
      op(csmsw_pkg::OP_DIRECT_RD, 16'h0081, 8'h00, 8'h30);
      op(csmsw_pkg::OP_POP, 16'h0000, 8'h00, 8'h55);
      op(csmsw_pkg::OP_DIRECT_RD, 16'h0081, 8'h00, 8'h2f);
      op(csmsw_pkg::OP_DIRECT_WR, 16'h0090, 8'h3c, 8'h3c);
      op(csmsw_pkg::OP_INDIRECT_WR, 16'h0090, 8'hc3, 8'hc3);
      op(csmsw_pkg::OP_DIRECT_RD, 16'h0090, 8'h00, 8'h3c);
      op(csmsw_pkg::OP_INDIRECT_RD, 16'h0090, 8'h00, 8'hc3);
      idle(0);
      @(negedge clk);
      check("base upper", rsp_base.rdata, 8'h00);
      check("port1", view.port_latch[1], 8'h3c);
      @(posedge clk);
      op(csmsw_pkg::OP_DIRECT_WR, 16'h0080, 8'h00, 8'h00);
      op(csmsw_pkg::OP_BIT_WR, 16'h0083, 8'h01, 8'h08);
      op(csmsw_pkg::OP_DIRECT_RD, 16'h0080, 8'h00, 8'h08);
      op(csmsw_pkg::OP_BIT_RD, 16'h0083, 8'h00, 8'h08);
      idle(0);
      @(negedge clk);
      check("bit", {7'h00, rsp.bit_val}, 8'h01);
      @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         // data must stay put until the cycle after the read is taken
         idle(2);
         rnd = next_rand(rnd);
         mem_rdata <= rnd;
         ext_fetch_only <= i[1];
         op(csmsw_pkg::OP_PROG_RD, 16'h1fff + 16'(i[0]), 8'h00, rnd);
         op(csmsw_pkg::OP_XDATA_WR, 16'hfff0, rnd, rnd);
         op(csmsw_pkg::OP_XDATA_RD, 16'h1fff, 8'h00, rnd);
      end
      idle(2);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      check("stack", view.stack_pointer, 8'h07);
      idle(2);
      summarize();
   end

   initial begin
      repeat (4000) @(posedge clk);
      fail_count++;
      summarize();
   end
endmodule
